// ---- qp_pkg.sv ----
// package for the quad pot two-wire slave port
// assumes a 20 MHz system clock and a sampled, slow serial link
package qp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int NV_WRITE_NS = 10_000_000;
  localparam int NV_WRITE_CYC = (NV_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // byte map
  localparam logic [3:0] ADDR_WR_LAST = 4'h3;
  localparam logic [3:0] ADDR_GP_LAST = 4'h6;
  localparam logic [3:0] ADDR_ACR = 4'h8;
  localparam logic [3:0] ADDR_LAST = 4'h8;
  localparam logic [3:0] ADDR_FIRST = 4'h0;
  localparam int NV_DEPTH = 8;
  localparam int NV_AW = 3;

  ////////////////////////////////////////////////////////////////////////////
  // reset and mode values
  localparam logic [7:0] WIPER_RST = 8'h80;
  localparam logic [7:0] IVR_RST = 8'h80;
  localparam logic [7:0] GP_RST = 8'h00;
  localparam logic [7:0] ACR_RST = 8'h00;
  localparam logic [7:0] ACR_VOL = 8'h80;
  localparam logic [7:0] TX_IDLE = 8'hff;

  ////////////////////////////////////////////////////////////////////////////
  // bit positions and power-up recall step count
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [2:0] PU_DONE = 3'h4;

  typedef enum logic [2:0] {
    ST_PWRUP = 3'b000,
    ST_IDLE  = 3'b001,
    ST_ID    = 3'b011,
    ST_ADDR  = 3'b010,
    ST_WDATA = 3'b110,
    ST_RDATA = 3'b111,
    ST_NVWR  = 3'b101,
    ST_DONE  = 3'b100
  } qp_state_t;

endpackage

// ---- qp_mem_if.sv ----
// carrier between the serial port and its non-volatile byte store
// assumes one clock shared by both ends
interface qp_mem_if;
  logic [2:0] raddr;
  logic [7:0] rdata;
  logic we;
  logic [2:0] waddr;
  logic [7:0] wdata;

  modport port (output raddr, input rdata, output we, output waddr, output wdata);
  modport mem (input raddr, output rdata, input we, input waddr, input wdata);
endinterface

// ---- qp_nv_mem.sv ----
// eight-byte non-volatile store, registered read
// assumes synchronous active-low reset stands in for the factory image
module qp_nv_mem import qp_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  qp_mem_if.mem m
);

  logic [7:0] mem_q [NV_DEPTH];
  logic [7:0] rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // storage, factory image on reset
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < NV_DEPTH; i++) begin
        mem_q[i] <= (i <= int'(ADDR_WR_LAST)) ? IVR_RST : GP_RST;
      end
    end else if (m.we) begin
      mem_q[m.waddr] <= m.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered read
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      rdata_q <= GP_RST;
    end else begin
      rdata_q <= mem_q[m.raddr];
    end
  end

  assign m.rdata = rdata_q;

endmodule

// ---- qp_pot_i2c_slave.sv ----
// two-wire slave port of a quad digital pot: wipers, access control, nv bytes
// assumes scl/sda/pins are asynchronous and sampled far faster than scl
module qp_pot_i2c_slave import qp_pkg::*; #(
  parameter logic [3:0] DEV_TYPE = 4'h5, // arbitrary type code
  parameter int NV_WRITE_CYCLES = NV_WRITE_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic addr_select_2_i,
  input wire logic addr_select_1_i,
  input wire logic addr_select_0_i,
  input wire logic wp_n_i,
  output logic [31:0] wiper_o,
  output logic [7:0] access_ctrl_o,
  output logic busy_o,
  output logic standby_o
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [3:0] next_ptr(input logic [3:0] p);
    return (p >= ADDR_LAST) ? ADDR_FIRST : p + 4'h1;
  endfunction

  function automatic logic [7:0] read_byte(input logic [3:0] p, input logic [7:0] acr,
                                           input logic [7:0] wr, input logic [7:0] nv);
    if (p == ADDR_ACR) begin
      return acr;
    end else if (p <= ADDR_WR_LAST && acr == ACR_VOL) begin
      return wr;
    end else begin
      return nv;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  qp_mem_if mif ();

  logic [1:0] scl_s;
  logic [1:0] sda_s;
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic scl_p_q;
  logic sda_p_q;
  qp_state_t state_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic ack_q;
  logic mack_q;
  logic rw_q;
  logic fill_en_q;
  logic [3:0] addr_q;
  logic [7:0] acr_q;
  logic [3:0][7:0] wiper_q;
  logic nv_pend_q;
  logic [2:0] nv_addr_q;
  logic [7:0] nv_data_q;
  logic mem_we_q;
  logic [31:0] timer_q;
  logic [2:0] pu_idx_q;
  logic sda_oe_q;
  logic [7:0] buf_q [2];
  logic [1:0] count_q;
  logic wr_idx_q;
  logic rd_idx_q;
  logic req_q;
  logic [3:0] req_ptr_q;
  logic [3:0] fptr_q;
  logic skip_fall_q;

  logic scl_w;
  logic sda_w;
  logic scl_rise;
  logic scl_fall;
  logic start_w;
  logic stop_w;
  logic link_act;
  logic wp_n_w;
  logic id_ok;
  logic byte_end;
  logic ack_end;
  logic flush_w;
  logic pop_w;
  logic issue_w;
  logic drive_d;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers and edge detect
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_s <= {scl_s[0], scl_i};
      sda_s <= {sda_s[0], sda_i};
      pin_s1 <= {wp_n_i, addr_select_2_i, addr_select_1_i, addr_select_0_i};
      pin_s2 <= pin_s1;
      scl_p_q <= scl_s[1];
      sda_p_q <= sda_s[1];
    end
  end

  assign scl_w = scl_s[1];
  assign sda_w = sda_s[1];
  assign wp_n_w = pin_s2[3];
  assign scl_rise = scl_w & ~scl_p_q;
  assign scl_fall = ~scl_w & scl_p_q;
  assign start_w = scl_w & scl_p_q & sda_p_q & ~sda_w;
  assign stop_w = scl_w & scl_p_q & ~sda_p_q & sda_w;
  assign link_act = !(start_w || stop_w) && state_q != ST_IDLE && state_q != ST_DONE;
  assign id_ok = shift_q[7:4] == DEV_TYPE && shift_q[3:1] == pin_s2[2:0];
  assign byte_end = link_act && scl_fall && bit_cnt_q == BIT_LAST;
  assign ack_end = link_act && scl_fall && bit_cnt_q == BIT_ACK;
  assign flush_w = byte_end && state_q == ST_ID && id_ok && shift_q[0];
  assign pop_w = ack_end && ((state_q == ST_ID && rw_q) || (state_q == ST_RDATA && mack_q));

  ////////////////////////////////////////////////////////////////////////////
  // protocol, power-up recall and nv write timer
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      state_q <= ST_PWRUP;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= TX_IDLE;
      ack_q <= 1'b0;
      mack_q <= 1'b0;
      rw_q <= 1'b0;
      fill_en_q <= 1'b0;
      addr_q <= ADDR_FIRST;
      acr_q <= ACR_RST;
      wiper_q <= {4{WIPER_RST}};
      nv_pend_q <= 1'b0;
      nv_addr_q <= 3'h0;
      nv_data_q <= 8'h00;
      mem_we_q <= 1'b0;
      timer_q <= 32'h0000_0000;
      pu_idx_q <= 3'h0;
      skip_fall_q <= 1'b0;
    end else begin
      mem_we_q <= 1'b0;
      unique case (state_q)
        ST_PWRUP: begin
          pu_idx_q <= pu_idx_q + 3'h1;
          if (pu_idx_q != 3'h0) begin
            wiper_q[2'(pu_idx_q - 3'h1)] <= mif.rdata;
          end
          if (pu_idx_q == PU_DONE) begin
            state_q <= ST_IDLE;
          end
        end
        ST_NVWR: begin
          timer_q <= timer_q - 32'h0000_0001;
          if (timer_q <= 32'h0000_0001) begin
            state_q <= ST_IDLE;
          end
        end
        ST_IDLE, ST_ID, ST_ADDR, ST_WDATA, ST_RDATA, ST_DONE: begin
          if (start_w) begin
            state_q <= ST_ID;
            bit_cnt_q <= 4'h0;
            ack_q <= 1'b0;
            tx_q <= TX_IDLE;
            nv_pend_q <= 1'b0;
            fill_en_q <= 1'b0;
            skip_fall_q <= 1'b1;
          end else if (stop_w) begin
            skip_fall_q <= 1'b0;
            bit_cnt_q <= 4'h0;
            ack_q <= 1'b0;
            tx_q <= TX_IDLE;
            fill_en_q <= 1'b0;
            nv_pend_q <= 1'b0;
            if (nv_pend_q) begin
              state_q <= ST_NVWR;
              timer_q <= 32'(NV_WRITE_CYCLES);
              mem_we_q <= 1'b1;
            end else begin
              state_q <= ST_IDLE;
            end
          end else if (link_act) begin
            if (scl_rise) begin
              if (bit_cnt_q < BIT_ACK) begin
                shift_q <= {shift_q[6:0], sda_w};
              end else if (state_q == ST_RDATA) begin
                mack_q <= ~sda_w;
              end
            end
            if (scl_fall && skip_fall_q) begin
              skip_fall_q <= 1'b0; // start's own clock fall
            end else if (scl_fall) begin
              if (bit_cnt_q < BIT_LAST) begin
                bit_cnt_q <= bit_cnt_q + 4'h1;
                if (state_q == ST_RDATA) begin
                  tx_q <= {tx_q[6:0], 1'b1};
                end
              end else if (bit_cnt_q == BIT_LAST) begin
                bit_cnt_q <= BIT_ACK;
                tx_q <= TX_IDLE;
                unique case (state_q)
                  ST_ID: begin
                    if (id_ok) begin
                      ack_q <= 1'b1;
                      rw_q <= shift_q[0];
                      fill_en_q <= shift_q[0];
                    end else begin
                      state_q <= ST_DONE;
                    end
                  end
                  ST_ADDR: begin
                    if (shift_q <= {4'h0, ADDR_LAST}) begin
                      ack_q <= 1'b1;
                      addr_q <= shift_q[3:0];
                    end else begin
                      state_q <= ST_DONE;
                    end
                  end
                  ST_WDATA: begin
                    if (!wp_n_w) begin
                      state_q <= ST_IDLE;
                    end else begin
                      ack_q <= 1'b1;
                      if (addr_q <= ADDR_WR_LAST) begin
                        wiper_q[addr_q[1:0]] <= shift_q;
                      end
                      if (addr_q == ADDR_ACR) begin
                        acr_q <= shift_q;
                      end
                      if (addr_q <= ADDR_GP_LAST && acr_q == ACR_RST) begin
                        nv_pend_q <= 1'b1;
                        nv_addr_q <= addr_q[2:0];
                        nv_data_q <= shift_q;
                      end
                    end
                  end
                  default: begin
                  end
                endcase
              end else begin
                bit_cnt_q <= 4'h0;
                ack_q <= 1'b0;
                unique case (state_q)
                  ST_ID: state_q <= rw_q ? ST_RDATA : ST_ADDR;
                  ST_ADDR: state_q <= ST_WDATA;
                  ST_WDATA: state_q <= ST_DONE;
                  ST_RDATA: begin
                    if (!mack_q) begin
                      state_q <= ST_DONE;
                      fill_en_q <= 1'b0;
                    end
                  end
                  default: begin
                  end
                endcase
                if (pop_w) begin
                  tx_q <= (count_q != 2'h0) ? buf_q[rd_idx_q] : TX_IDLE;
                end
              end
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // two-entry read buffer, prefetch stalls while full
  assign issue_w = fill_en_q && !flush_w && (2'(count_q + {1'b0, req_q}) < 2'h2);

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i || flush_w) begin
      count_q <= 2'h0;
      wr_idx_q <= 1'b0;
      rd_idx_q <= 1'b0;
      req_q <= 1'b0;
      req_ptr_q <= ADDR_FIRST;
      fptr_q <= flush_w ? addr_q : ADDR_FIRST;
      buf_q[0] <= TX_IDLE;
      buf_q[1] <= TX_IDLE;
    end else begin
      req_q <= issue_w;
      if (issue_w) begin
        req_ptr_q <= fptr_q;
        fptr_q <= next_ptr(fptr_q);
      end
      if (req_q) begin
        buf_q[wr_idx_q] <= read_byte(req_ptr_q, acr_q, wiper_q[req_ptr_q[1:0]], mif.rdata);
        wr_idx_q <= ~wr_idx_q;
      end
      if (pop_w && count_q != 2'h0) begin
        rd_idx_q <= ~rd_idx_q;
      end
      count_q <= 2'(count_q + {1'b0, req_q} - {1'b0, pop_w && count_q != 2'h0});
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // nv store
  assign mif.raddr = (state_q == ST_PWRUP) ? pu_idx_q[NV_AW-1:0] : fptr_q[NV_AW-1:0];
  assign mif.we = mem_we_q;
  assign mif.waddr = nv_addr_q;
  assign mif.wdata = nv_data_q;

  qp_nv_mem u_nv (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .m(mif.mem)
  );

  ////////////////////////////////////////////////////////////////////////////
  // open-drain data pin
  always_comb begin
    drive_d = 1'b0;
    if (state_q != ST_NVWR && state_q != ST_PWRUP && !start_w && !stop_w) begin
      drive_d = ack_q || (state_q == ST_RDATA && bit_cnt_q < BIT_ACK && !tx_q[7]);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      sda_oe_q <= 1'b0;
    end else begin
      sda_oe_q <= drive_d;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = sda_oe_q;
  assign wiper_o = wiper_q;
  assign access_ctrl_o = acr_q;
  assign busy_o = state_q == ST_NVWR || state_q == ST_PWRUP;
  assign standby_o = state_q == ST_IDLE;

endmodule

// ---- qp_pot_i2c_slave_chk.sv ----
// checker for the quad pot two-wire slave port
// assumes only top ports, one clock, sync active-low reset
module qp_chk #(
  parameter logic [3:0] DEV_TYPE = 4'h5,
  parameter int NV_WRITE_CYCLES = 50
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic [31:0] wiper_o,
  input wire logic [7:0] access_ctrl_o,
  input wire logic busy_o,
  input wire logic standby_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  logic [31:0] busy_cnt_q;
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i || !busy_o) busy_cnt_q <= 32'h0000_0000;
    else busy_cnt_q <= busy_cnt_q + 32'h0000_0001;
  end
  ////////////////////////////////////////////////////////////
  sequence s_held; sda_oe_o [*5]; endsequence
  sequence s_boot; busy_o && wiper_o == 32'h8080_8080 && access_ctrl_o == 8'h00; endsequence
  sequence s_long; $fell(busy_o) && busy_cnt_q > 32'h0000_0010; endsequence
  property p_drain; sda_oe_o |-> !sda_o; endproperty
  property p_busy_q; busy_o |-> !sda_oe_o; endproperty
  property p_sb_q; standby_o |-> !sda_oe_o; endproperty
  property p_oe_low; $changed(sda_oe_o) |-> !scl_i; endproperty
  property p_held; $rose(sda_oe_o) |=> s_held; endproperty
  property p_boot; $rose(rstn_i) |-> s_boot ##[1:20] standby_o; endproperty
  property p_nv_len; s_long |->
    busy_cnt_q >= NV_WRITE_CYCLES - 1 && busy_cnt_q <= NV_WRITE_CYCLES + 2; endproperty
  property p_sb_after; $fell(busy_o) |-> ##[0:2] standby_o; endproperty
  property p_frozen; busy_o && busy_cnt_q > 32'h0000_0010 |-> $stable(wiper_o); endproperty
  property p_wp_low; $changed(wiper_o) && !busy_o && !$past(busy_o) |-> !scl_i; endproperty
  a_drain: assert property (p_drain) else $error("data driven high");
  a_busy_q: assert property (p_busy_q) else $error("driven while busy");
  a_sb_q: assert property (p_sb_q) else $error("driven in standby");
  a_oe_low: assert property (p_oe_low) else $error("data moved in clock high");
  a_held: assert property (p_held) else $error("drive too short");
  a_boot: assert property (p_boot) else $error("bad power-up");
  a_nv_len: assert property (p_nv_len) else $error("bad nv write length");
  a_sb_after: assert property (p_sb_after) else $error("no standby after busy");
  a_frozen: assert property (p_frozen) else $error("wiper moved in nv write");
  a_wp_low: assert property (p_wp_low) else $error("wiper moved in clock high");
endmodule

bind qp_pot_i2c_slave qp_chk #(.DEV_TYPE(DEV_TYPE), .NV_WRITE_CYCLES(NV_WRITE_CYCLES)) chk_i (
  .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .wiper_o(wiper_o), .access_ctrl_o(access_ctrl_o), .busy_o(busy_o), .standby_o(standby_o));

// ---- qp_mst.sv ----
// two-wire bus master model, pulls data low or releases it
// assumes a wired-and data line with a pull-up in the bench
module qp_mst (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  task automatic start();
    @(posedge clk_i) #1;
    #100 sda_low_o = 1'b0;
    #150 scl_o = 1'b1;
    #150 sda_low_o = 1'b1;
    #150 scl_o = 1'b0;
  endtask
  task automatic stop();
    @(posedge clk_i) #1;
    #100 sda_low_o = 1'b1;
    #150 scl_o = 1'b1;
    #150 sda_low_o = 1'b0;
    #150;
  endtask
  task automatic bit_io(input logic b, output logic s);
    @(posedge clk_i) #1;
    sda_low_o = !b;
    #50 scl_o = 1'b1;
    #50 s = sda_i;
    #50 scl_o = 1'b0;
    #200;
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack_n);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, ack_n);
  endtask
  task automatic rd_byte(input logic ack_n, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(ack_n, s);
  endtask
endmodule

// ---- tb_qp_pot_i2c_slave.sv ----
// self-checking bench for the quad pot two-wire slave port
// assumes the master model, the bound checker and qp_pkg
module tb_qp_pot_i2c_slave import qp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] DEV = 4'h9; // arbitrary type code
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic wp_n = 1'b1;
  logic [2:0] sel = 3'b101;
  logic scl, sda_low, sda_oe, sda_dev, busy, standby;
  logic [31:0] wiper;
  logic [7:0] acr;
  int err_count = 0;
  int check_count = 0;
  wire sda = !(sda_low || (sda_oe && !sda_dev));
  always #25 ref_clk_i = !ref_clk_i;
  qp_pot_i2c_slave #(.DEV_TYPE(DEV), .NV_WRITE_CYCLES(400)) qp_pot_i2c_slave_i (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_dev),
    .sda_oe_o(sda_oe), .addr_select_2_i(sel[2]), .addr_select_1_i(sel[1]),
    .addr_select_0_i(sel[0]), .wp_n_i(wp_n), .wiper_o(wiper), .access_ctrl_o(acr),
    .busy_o(busy), .standby_o(standby));
  qp_mst qp_mst_i (.clk_i(ref_clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic id(input logic r, input logic [2:0] s, output logic a);
    qp_mst_i.start();
    qp_mst_i.wr_byte({DEV, s, r}, a);
  endtask
  task automatic wait_sb();
    for (int i = 0; i < 1000 && standby !== 1'b1; i++) @(posedge ref_clk_i) #1;
    chk("standby", standby, 1'b1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ea);
    logic k;
    id(1'b0, sel, k);
    chk("id ack", k, 1'b0);
    qp_mst_i.wr_byte(a, k);
    chk("addr ack", k, 1'b0);
    qp_mst_i.wr_byte(d, k);
    chk("data ack", k, ea);
    qp_mst_i.stop();
  endtask
  task automatic rd(input logic [7:0] a, input int n, input logic [47:0] e);
    logic k;
    logic [7:0] d;
    id(1'b0, sel, k);
    qp_mst_i.wr_byte(a, k);
    id(1'b1, sel, k);
    chk("rd id ack", k, 1'b0);
    for (int i = 0; i < n; i++) begin
      qp_mst_i.rd_byte(i == n - 1, d);
      chk("rd data", d, e[47 - 8 * i -: 8]);
    end
    qp_mst_i.stop();
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_boot();
    chk("wiper boot", wiper, 32'h8080_8080);
    chk("acr boot", acr, 8'h00);
    wait_sb();
  endtask
  task automatic t_nv();
    logic k;
    wr(8'h02, 8'h3c, 1'b0);
    chk("wiper nv", wiper, 32'h803c_8080);
    chk("busy nv", busy, 1'b1);
    id(1'b0, sel, k);
    chk("ack in busy", k, 1'b1);
    qp_mst_i.stop();
    wait_sb();
    rd(8'h02, 1, {8'h3c, 40'h00_0000_0000});
  endtask
  task automatic t_wrap();
    rd(8'h06, 6, {8'h00, 8'h00, 8'h00, 8'h80, 8'h80, 8'h3c});
  endtask
  task automatic t_vol();
    wr(8'h08, ACR_VOL, 1'b0);
    wait_sb();
    chk("acr vol", acr, ACR_VOL);
    wr(8'h01, 8'h55, 1'b0);
    chk("busy vol", busy, 1'b0);
    wait_sb();
    chk("wiper vol", wiper, 32'h803c_5580);
    rd(8'h01, 1, {8'h55, 40'h00_0000_0000});
    wr(8'h08, 8'h00, 1'b0);
    wait_sb();
    rd(8'h01, 1, {8'h80, 40'h00_0000_0000});
  endtask
  task automatic t_refuse();
    logic k;
    @(posedge ref_clk_i) #1 sel = 3'b010;
    id(1'b0, 3'b101, k);
    chk("bad id ack", k, 1'b1);
    qp_mst_i.stop();
    @(posedge ref_clk_i) #1 sel = 3'b101;
    id(1'b0, sel, k);
    qp_mst_i.wr_byte(8'h09, k);
    chk("bad addr ack", k, 1'b1);
    qp_mst_i.stop();
    @(posedge ref_clk_i) #1 wp_n = 1'b0;
    wr(8'h03, 8'h11, 1'b1);
    @(posedge ref_clk_i) #1 wp_n = 1'b1;
    wait_sb();
    chk("wiper wp", wiper, 32'h803c_5580);
  endtask
  initial begin
    repeat (4) @(posedge ref_clk_i);
    #1 rstn_i = 1'b1;
    t_boot();
    t_nv();
    t_wrap();
    t_vol();
    t_refuse();
    end_of_test();
  end
  initial begin
    #3_000_000;
    err_count++;
    end_of_test();
  end
endmodule
